// ### dxb_port.v
// external parallel bus port: clock divider, strobe sequencer, hold, flag, branch test
`timescale 1ns/1ps
`include "dxb_map.vh"
module dxb_port #(
    parameter AW = 16,
    parameter DW = 16
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // core request side
    input wire req_valid,
    input wire req_write,
    input wire [1:0] req_space,
    input wire req_global,
    input wire [AW-1:0] req_addr,
    input wire [DW-1:0] req_wdata,
    output wire req_ready,
    output reg rsp_valid,
    output reg [DW-1:0] rsp_rdata,
    // core control side
    input wire flag_set,
    input wire flag_clr,
    input wire branch_exec,
    output reg branch_taken,
    output reg branch_done,
    input wire fsync_out_en,
    input wire fsync_drive,
    output wire fsync_level,
    // clock output
    output reg master_clock_out,
    // address bus
    output reg [AW-1:0] addr_o,
    output wire addr_oe_n,
    // data bus, three signals
    input wire [DW-1:0] data_i,
    output reg [DW-1:0] data_o,
    output wire data_oe_n,
    // space selects and control, active low, tri-statable
    output reg program_space_select_n,
    output reg data_space_select_n,
    output reg io_space_select_n,
    output reg transfer_strobe_n,
    output reg rd_wr_n,
    output wire ctrl_oe_n,
    // handshake pins
    input wire ready,
    input wire hold_n,
    output reg hold_acknowledge_n,
    output reg global_bus_request_n,
    // flag and branch test
    output reg software_flag_out,
    input wire branch_test_input,
    // tx frame sync pin
    input wire tx_frame_sync_i,
    output wire tx_frame_sync_o,
    output wire tx_frame_sync_oe_n
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_TRANSFER_STROBE = 2'h2;
    localparam ST_HOLD = 2'h3;

    reg [1:0] state_r; // bus sequencer state
    reg [1:0] state_nxt;
    reg [1:0] div_r; // quarter-rate divider
    reg float_r; // bus lines released
    reg wr_drive_r; // data driven during write strobe
    reg [2:0] transfer_strobe_cnt_r; // strobe age, saturates at the synchroniser latency
    wire rdy_ok; // ready that belongs to the current strobe
    wire ready_s; // synchronised pins
    wire hold_n_s;
    wire bio_s;
    wire fsx_s;

    // pin synchronisers; hold reset high so no hold is seen at release
    dxb_sync #(.RST_VAL(1'b0)) u_rdy (.clk(clk), .nrst(nrst), .pin_in(ready),
        .level_out(ready_s));
    dxb_sync #(.RST_VAL(1'b1)) u_hld (.clk(clk), .nrst(nrst), .pin_in(hold_n),
        .level_out(hold_n_s));
    dxb_sync #(.RST_VAL(1'b1)) u_bio (.clk(clk), .nrst(nrst), .pin_in(branch_test_input),
        .level_out(bio_s));
    dxb_sync #(.RST_VAL(1'b0)) u_fsx (.clk(clk), .nrst(nrst), .pin_in(tx_frame_sync_i),
        .level_out(fsx_s));

    // divide by four: two cycles high, two low
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= 2'h0;
            master_clock_out <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            master_clock_out <= (div_r <= `DXB_CLK_HALF);
        end
    end

    // one request at a time, only from idle
    assign req_ready = (state_r == ST_IDLE) && hold_n_s;

    // strobe age counter; the synchronised ready lags the pin by four edges,
    // so a ready left high by the last transfer would end the next one early
    // trade-off: a strobe lasts at least this long even on fast memory
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            transfer_strobe_cnt_r <= 3'h0;
        end else if (state_r != ST_TRANSFER_STROBE) begin
            transfer_strobe_cnt_r <= 3'h0; // restart for every strobe
        end else if (transfer_strobe_cnt_r != `DXB_RDY_LAT) begin
            transfer_strobe_cnt_r <= transfer_strobe_cnt_r + 3'h1;
        end
    end

    // ready only counts once it can reflect the current strobe
    assign rdy_ok = ready_s && (transfer_strobe_cnt_r == `DXB_RDY_LAT);

    // sequencer next state; hold only taken between transfers
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (!hold_n_s) begin
                    state_nxt = ST_HOLD;
                end else if (req_valid) begin
                    state_nxt = ST_ADDR;
                end
            end
            ST_ADDR: begin
                state_nxt = ST_TRANSFER_STROBE;
            end
            ST_TRANSFER_STROBE: begin
                // wait states until the peripheral reports done
                if (rdy_ok) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (hold_n_s) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // bus pin registers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            addr_o <= `DXB_ADDR_RST;
            data_o <= `DXB_DATA_RST;
            rsp_rdata <= `DXB_DATA_RST;
            rsp_valid <= 1'b0;
            program_space_select_n <= 1'b1;
            data_space_select_n <= 1'b1;
            io_space_select_n <= 1'b1;
            transfer_strobe_n <= 1'b1;
            rd_wr_n <= 1'b1;
            global_bus_request_n <= 1'b1;
            hold_acknowledge_n <= 1'b1;
            float_r <= 1'b0;
            wr_drive_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rsp_valid <= 1'b0;
            // float lines and acknowledge while held
            float_r <= (state_nxt == ST_HOLD);
            hold_acknowledge_n <= !(state_nxt == ST_HOLD);
            if (state_r == ST_IDLE && state_nxt == ST_ADDR) begin
                addr_o <= req_addr;
                data_o <= req_wdata;
                rd_wr_n <= !req_write;
                program_space_select_n <= !(req_space == `DXB_SPACE_PROG);
                data_space_select_n <= !(req_space == `DXB_SPACE_DATA);
                io_space_select_n <= !(req_space == `DXB_SPACE_IO);
                global_bus_request_n <= !(req_global && req_space == `DXB_SPACE_DATA);
            end
            if (state_r == ST_ADDR) begin
                transfer_strobe_n <= 1'b0;
                wr_drive_r <= !rd_wr_n;
            end
            if (state_r == ST_TRANSFER_STROBE && rdy_ok) begin
                // end of transfer: drop strobe, selects, request
                transfer_strobe_n <= 1'b1;
                wr_drive_r <= 1'b0;
                program_space_select_n <= 1'b1;
                data_space_select_n <= 1'b1;
                io_space_select_n <= 1'b1;
                global_bus_request_n <= 1'b1;
                rd_wr_n <= 1'b1;
                rsp_valid <= 1'b1;
                if (rd_wr_n) begin
                    rsp_rdata <= data_i;
                end
            end
        end
    end

    // enables low while driving
    assign addr_oe_n = float_r;
    assign ctrl_oe_n = float_r;
    assign data_oe_n = !wr_drive_r || float_r;

    // software flag latch; set wins over clear
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            software_flag_out <= `DXB_FLAG_RST;
        end else if (flag_set) begin
            software_flag_out <= 1'b1;
        end else if (flag_clr) begin
            software_flag_out <= 1'b0;
        end
    end

    // branch test: sampled at instruction, taken on low level
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            branch_taken <= 1'b0;
            branch_done <= 1'b0;
        end else begin
            branch_done <= branch_exec;
            if (branch_exec) begin
                branch_taken <= !bio_s;
            end
        end
    end

    // frame sync direction; input path is synchronised, output is core level
    assign tx_frame_sync_o = fsync_drive;
    assign tx_frame_sync_oe_n = !fsync_out_en;
    assign fsync_level = fsync_out_en ? fsync_drive : fsx_s;
endmodule

// ### dxb_map.vh
// constants for the external bus port: spaces, clock divide, pin timing
// Function
// - master clock out is input clock over four
// - one shared 16-bit bidirectional data bus
// - drive 16-bit address bus, tri-statable
// - separate program, data, io space selects
// - bus request asserted for global data memory access
// - hold idles port, floats bus, acknowledges
// - software flag output held in latch
// - branch test input sampled on branch instruction
// - tx frame sync configurable input or output
`ifndef DXB_MAP_VH
`define DXB_MAP_VH
`define DXB_SPACE_PROG 2'h0
`define DXB_SPACE_DATA 2'h1
`define DXB_SPACE_IO 2'h2
`define DXB_CLK_DIV 3'h4
`define DXB_CLK_HALF 2'h1
`define DXB_RDY_LAT 3'h4
`define DXB_ADDR_RST 16'h0000
`define DXB_DATA_RST 16'h0000
`define DXB_FLAG_RST 1'h0
`endif

// ### dxb_sync.v
// three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/1ps
module dxb_sync #(
    parameter RST_VAL = 1'b0
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // pin side
    input wire pin_in,
    // filtered level
    output reg level_out
);
    reg s1_r; // first stage, read only by s2_r
    reg s2_r;
    reg s3_r;

    // shift chain; output changes only when stages two and three agree
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            level_out <= RST_VAL;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule

// ### dxb_port_props.sv
// assertions on the external bus port pins
`timescale 1ns/1ps
module dxb_props (
    // clock and reset
    input wire clk,
    input wire nrst,
    // core side
    input wire req_valid,
    input wire req_ready,
    input wire [1:0] req_space,
    input wire [15:0] req_addr,
    input wire flag_set,
    // pins
    input wire [15:0] addr_o,
    input wire master_clock_out,
    input wire data_space_select_n,
    input wire transfer_strobe_n,
    input wire rd_wr_n,
    input wire hold_acknowledge_n,
    input wire addr_oe_n,
    input wire data_oe_n,
    input wire ctrl_oe_n,
    input wire global_bus_request_n,
    input wire ready,
    input wire software_flag_out
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
// two high then two low after each rise
sequence s_div; master_clock_out ##1 !master_clock_out [*2] ##1 master_clock_out; endsequence
sequence s_take; req_valid && req_ready; endsequence
property p_div; $rose(master_clock_out) |=> s_div; endproperty
a_div: assert property (p_div) else $error("clock out period");
property p_addr; s_take |=> addr_o == $past(req_addr); endproperty
a_addr: assert property (p_addr) else $error("address out");
property p_sel; s_take ##0 req_space == 2'h1 |=> !data_space_select_n ##1 !transfer_strobe_n; endproperty
a_sel: assert property (p_sel) else $error("data select");
property p_hold; !hold_acknowledge_n |-> addr_oe_n && data_oe_n && ctrl_oe_n; endproperty
a_hold: assert property (p_hold) else $error("hold float");
property p_breq; $fell(global_bus_request_n) |-> $fell(data_space_select_n); endproperty
a_breq: assert property (p_breq) else $error("bus request");
property p_wr; !data_oe_n |-> !rd_wr_n && !transfer_strobe_n; endproperty
a_wr: assert property (p_wr) else $error("data drive");
// a ready pin low this long cannot have been seen high yet
property p_wait; !ready [*5] ##0 !transfer_strobe_n |=> !transfer_strobe_n; endproperty
a_wait: assert property (p_wait) else $error("strobe ended early");
property p_flag; flag_set |=> software_flag_out; endproperty
a_flag: assert property (p_flag) else $error("flag set");
endmodule
bind dxb_port dxb_props dxb_props_inst (.*);

// ### dxb_mem.sv
// external memory model with programmable wait states
`timescale 1ns/1ps
module dxb_mem (
    // clock
    input wire clk,
    // bus pins from the port
    input wire [15:0] addr_o,
    input wire [15:0] data_o,
    input wire data_oe_n,
    input wire transfer_strobe_n,
    input wire rd_wr_n,
    // wait states before ready
    input wire [3:0] wait_cnt,
    // answers to the port
    output wire ready,
    output wire [15:0] data_i
);
// sixteen words tell the test addresses apart
logic [15:0] mem [16];
logic [3:0] cnt = 4'h0;
// count strobe cycles, store writes while strobed
always @(posedge clk) begin
    cnt <= transfer_strobe_n ? 4'h0 : cnt + 4'h1;
    if (!transfer_strobe_n && !rd_wr_n) mem[addr_o[3:0]] <= data_o;
end
// ready only once the wait states are spent
assign ready = !transfer_strobe_n && cnt >= wait_cnt;
// a released bus shows the inverted address, never a stale word
assign data_i = !data_oe_n ? data_o : (!transfer_strobe_n && rd_wr_n) ? mem[addr_o[3:0]] : ~addr_o;
endmodule

// ### dxb_port_bench.sv
// self-checking bench for the external bus port
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
`define WAIT(c) begin i = 0; while (!(c) && i < 60) begin @(posedge clk); i++; end \
    if (i >= 60) begin bad_count++; end_of_test; end end
module dxb_port_bench;
// bench-driven inputs
logic clk = 0, nrst = 0, req_valid = 0, req_write = 0, req_global = 0, flag_set = 0;
logic flag_clr = 0, branch_exec = 0, fsync_out_en = 0, fsync_drive = 0, hold_n = 1;
logic branch_test_input = 0, fs_ext = 0;
logic [1:0] req_space = 0;
logic [3:0] wait_cnt = 0;
logic [15:0] req_addr = 0, req_wdata = 0;
// design outputs and partner pins
wire req_ready, rsp_valid, branch_taken, branch_done, fsync_level, master_clock_out;
wire addr_oe_n, data_oe_n, program_space_select_n, data_space_select_n, io_space_select_n;
wire transfer_strobe_n, rd_wr_n, ctrl_oe_n, ready, hold_acknowledge_n, global_bus_request_n;
wire software_flag_out, tx_frame_sync_o, tx_frame_sync_oe_n;
wire [15:0] rsp_rdata, addr_o, data_o, data_i;
// frame sync pin level from whichever side drives it
wire tx_frame_sync_i = tx_frame_sync_oe_n ? fs_ext : tx_frame_sync_o;
int bad_count = 0, num_checks = 0, i;
dxb_port dxb_port_inst (.*);
dxb_mem dxb_mem_inst (.*);
always #2 clk = ~clk;
task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
// one transfer; values sampled during the strobe
task automatic xfer(input logic w, input logic [1:0] sp, input logic g,
    input logic [15:0] a, input logic [15:0] d, input logic [3:0] ws);
    `WAIT(req_ready)
    @(posedge clk);
    {wait_cnt, req_write, req_space, req_global, req_addr, req_wdata} <= {ws, w, sp, g, a, d};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    `WAIT(!transfer_strobe_n)
    `CHK("sel", ~(3'b100 >> sp), {program_space_select_n, data_space_select_n, io_space_select_n})
    `CHK("rw", ~w, rd_wr_n)
    `CHK("breq", ~g, global_bus_request_n)
    `CHK("doe", ~w, data_oe_n)
    `CHK("addr", a, addr_o)
    `WAIT(rsp_valid)
    if (!w) `CHK("rdata", d, rsp_rdata)
    $display("xfer %h end", a);
endtask
// bus handed to another master and back
task hold_test;
    @(posedge clk);
    hold_n <= 1'b0;
    `WAIT(!hold_acknowledge_n)
    `CHK("float", 4'he, {addr_oe_n, data_oe_n, ctrl_oe_n, req_ready})
    hold_n <= 1'b1;
    `WAIT(hold_acknowledge_n)
    `CHK("drive", 1'b0, addr_oe_n)
    $display("hold end");
endtask
// set beats clear when both arrive together
task flag_test;
    @(posedge clk);
    {flag_set, flag_clr} <= 2'h3;
    @(posedge clk);
    {flag_set, flag_clr} <= 2'h0;
    @(posedge clk);
    `CHK("fset", 1'b1, software_flag_out)
    flag_clr <= 1'b1;
    @(posedge clk);
    flag_clr <= 1'b0;
    @(posedge clk);
    `CHK("fclr", 1'b0, software_flag_out)
    $display("flag end");
endtask
// pin settles through the synchroniser before the test
task branch_test(input logic b);
    @(posedge clk);
    branch_test_input <= b;
    repeat (6) @(posedge clk);
    branch_exec <= 1'b1;
    @(posedge clk);
    branch_exec <= 1'b0;
    @(posedge clk);
    `CHK("branch", {1'b1, ~b}, {branch_done, branch_taken})
    $display("branch end");
endtask
task fsync_test;
    @(posedge clk);
    {fsync_out_en, fsync_drive} <= 2'h3;
    @(posedge clk);
    `CHK("fsout", 2'h1, {tx_frame_sync_oe_n, tx_frame_sync_o})
    // core level low, far side high: only the pin path can give a one
    {fsync_out_en, fsync_drive, fs_ext} <= 3'h1;
    // the pin passes the three-flop synchroniser and its agreement filter
    repeat (4) @(posedge clk);
    `CHK("fsin", 2'h3, {tx_frame_sync_oe_n, fsync_level})
    $display("fsync end");
endtask
initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (logic [1:0] s = 0; s < 3; s++) begin
        xfer(1'b1, s, 1'b0, 16'h0010 + s, 16'h5a00 + s, 4'h0);
        xfer(1'b0, s, 1'b0, 16'h0010 + s, 16'h5a00 + s, 4'h3 * s);
    end
    xfer(1'b1, 2'h1, 1'b1, 16'hfffe, 16'h0f0f, 4'h1);
    xfer(1'b0, 2'h1, 1'b1, 16'hfffe, 16'h0f0f, 4'h0);
    hold_test;
    flag_test;
    branch_test(1'b0);
    branch_test(1'b1);
    fsync_test;
    end_of_test;
end
endmodule
